//--- hw/ssle_pkg.sv
// Shared constants, types and register map of the scanner status indicator encoder
package ssle_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned TRAFFIC_HALF_MS = 50;
  localparam int unsigned TRAFFIC_HALF_CYC = CLK_HZ / 1000 * TRAFFIC_HALF_MS;

  localparam logic [11:0] REG_CTRL_ADDR = 12'h000;
  localparam logic [11:0] REG_STAT_ADDR = 12'h004;
  localparam logic [11:0] REG_TOCLR_ADDR = 12'h008;

  localparam int CTRL_SELFTEST_BIT = 0;
  localparam int CTRL_CONFIGURED_BIT = 1;
  localparam int CTRL_MAJOR_BIT = 2;
  localparam int CTRL_MINOR_BIT = 3;
  localparam int CTRL_BADCFG_BIT = 4;
  localparam int CTRL_HAVE_IP_BIT = 5;
  localparam int CTRL_DUP_IP_BIT = 6;
  localparam int CTRL_CONN_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    IND_OFF,
    IND_GREEN,
    IND_RED
  } ssle_colour_t;

  typedef enum {
    PAT_DARK,
    PAT_GREEN_ON,
    PAT_GREEN_FLASH,
    PAT_RED_ON,
    PAT_RED_FLASH,
    PAT_ALTERNATE
  } ssle_pattern_t;

  typedef struct packed {
    logic green;
    logic red;
  } ssle_duo_t;

  typedef struct packed {
    logic link;
    logic traffic;
  } ssle_port_leds_t;
endpackage : ssle_pkg

//--- hw/ssle_prescaler.sv
// Free-running half-period prescaler producing a square wave
`timescale 1ns/1ps
module ssle_prescaler #(
  parameter int unsigned HALF_CYC = 25_000_000
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic phase
);
  logic [31:0] count_r;
  logic phase_r;
  wire wrap = (count_r == 32'(HALF_CYC - 1));

  // Equal on and off halves
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_r <= 32'h0;
      phase_r <= 1'b0;
    end else begin
      count_r <= wrap ? 32'h0 : count_r + 32'h1;
      phase_r <= wrap ? ~phase_r : phase_r;
    end
  end
  assign phase = phase_r;

  chk_phase_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !wrap |=> $stable(phase_r)) else $error("prescaler phase moved early");
endmodule : ssle_prescaler

//--- hw/ssle_port_leds.sv
// Link and traffic indicator driver for one Ethernet port
`timescale 1ns/1ps
module ssle_port_leds (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_up,
  input wire logic frame_seen,
  input wire logic flicker,
  output ssle_pkg::ssle_port_leds_t leds
);
  logic busy_r;
  logic flick_d_r;
  ssle_pkg::ssle_port_leds_t leds_r;
  // Activity held until the next rising edge of flicker, so short frames stay visible
  wire flick_rise = flicker & ~flick_d_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
      flick_d_r <= 1'b0;
      leds_r <= '0;
    end else begin
      flick_d_r <= flicker;
      busy_r <= frame_seen | (busy_r & ~flick_rise);
      leds_r.link <= link_up;
      leds_r.traffic <= link_up & (busy_r | frame_seen) & flicker;
    end
  end
  assign leds = leds_r;

  chk_link_follow: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 leds_r.link == $past(link_up)) else $error("link led off its input");
  chk_traffic_idle: assert property (@(posedge sys_clk) disable iff (reset)
    !link_up |=> !leds_r.traffic) else $error("traffic led lit without link");
endmodule : ssle_port_leds

//--- hw/ssle_top.sv
// Status indicator encoder with AXI4-Lite condition registers
`timescale 1ns/1ps
module ssle_top #(
  parameter int unsigned FLASH_HALF_CYC = ssle_pkg::FLASH_HALF_CYC,
  parameter int unsigned TRAFFIC_HALF_CYC = ssle_pkg::TRAFFIC_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conn_timeout_evt,
  input wire logic conn_all_restored,
  input wire logic port_zero_link,
  input wire logic port_zero_frame,
  input wire logic port_one_link,
  input wire logic port_one_frame,
  output ssle_pkg::ssle_duo_t module_state_indicator,
  output ssle_pkg::ssle_duo_t network_state_indicator,
  output ssle_pkg::ssle_port_leds_t port_zero_leds,
  output ssle_pkg::ssle_port_leds_t port_one_leds
);
  logic [7:0] ctrl_r;
  logic timeout_r;
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  ssle_pkg::ssle_duo_t ms_r;
  ssle_pkg::ssle_duo_t ns_r;
  logic flash;
  logic flicker;

  // Write channel: address and data taken in either order
  wire aw_take = s_axi_awvalid & ~aw_held_r & ~bvalid_r;
  wire w_take = s_axi_wvalid & ~w_held_r & ~bvalid_r;
  wire aw_have = aw_held_r | aw_take;
  wire w_have = w_held_r | w_take;
  wire wr_fire = aw_have & w_have & ~bvalid_r;
  wire [11:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_ctrl = wr_fire & (wr_addr == ssle_pkg::REG_CTRL_ADDR) & wr_strb[0];
  wire wr_toclr = wr_fire & (wr_addr == ssle_pkg::REG_TOCLR_ADDR) & wr_strb[0] & wr_data[0];
  wire wr_mapped = (wr_addr == ssle_pkg::REG_CTRL_ADDR) | (wr_addr == ssle_pkg::REG_TOCLR_ADDR);

  wire rd_take = s_axi_arvalid & ~rvalid_r;
  wire [31:0] status_word = {22'h0, port_one_leds.link, port_zero_leds.link,
    module_state_indicator, network_state_indicator, timeout_r, 3'h0};
  wire rd_ctrl = (s_axi_araddr == ssle_pkg::REG_CTRL_ADDR);
  wire rd_stat = (s_axi_araddr == ssle_pkg::REG_STAT_ADDR);
  wire [31:0] rd_word = rd_ctrl ? {24'h0, ctrl_r} : (rd_stat ? status_word : 32'h0);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= ssle_pkg::RESP_OKAY;
    end else begin
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) wdata_r <= s_axi_wdata;
      if (w_take) wstrb_r <= s_axi_wstrb;
      aw_held_r <= wr_fire ? 1'b0 : aw_have;
      w_held_r <= wr_fire ? 1'b0 : w_have;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? ssle_pkg::RESP_OKAY : ssle_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= ssle_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_ctrl | rd_stat) ? ssle_pkg::RESP_OKAY : ssle_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Timeout flag: new timeout wins over any clear in the same cycle
  wire to_clear = conn_all_restored | wr_toclr;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= ssle_pkg::CTRL_RESET;
      timeout_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= wr_data[7:0];
      timeout_r <= conn_timeout_evt | (timeout_r & ~to_clear);
    end
  end

  wire selftest = ctrl_r[ssle_pkg::CTRL_SELFTEST_BIT];
  wire configured = ctrl_r[ssle_pkg::CTRL_CONFIGURED_BIT];
  wire major = ctrl_r[ssle_pkg::CTRL_MAJOR_BIT];
  wire minor = ctrl_r[ssle_pkg::CTRL_MINOR_BIT] | ctrl_r[ssle_pkg::CTRL_BADCFG_BIT];
  wire have_ip = ctrl_r[ssle_pkg::CTRL_HAVE_IP_BIT];
  wire dup_ip = ctrl_r[ssle_pkg::CTRL_DUP_IP_BIT];
  wire connected = ctrl_r[ssle_pkg::CTRL_CONN_BIT];

  ssle_prescaler #(.HALF_CYC(FLASH_HALF_CYC)) u_flash (
    .sys_clk(sys_clk),
    .reset(reset),
    .phase(flash)
  );
  ssle_prescaler #(.HALF_CYC(TRAFFIC_HALF_CYC)) u_flicker (
    .sys_clk(sys_clk),
    .reset(reset),
    .phase(flicker)
  );

  ssle_pkg::ssle_pattern_t ms_pat;
  ssle_pkg::ssle_pattern_t ns_pat;
  always_comb begin
    if (selftest) ms_pat = ssle_pkg::PAT_ALTERNATE;
    else if (major) ms_pat = ssle_pkg::PAT_RED_ON;
    else if (minor) ms_pat = ssle_pkg::PAT_RED_FLASH;
    else if (!configured) ms_pat = ssle_pkg::PAT_GREEN_FLASH;
    else ms_pat = ssle_pkg::PAT_GREEN_ON;
  end
  always_comb begin
    if (selftest) ns_pat = ssle_pkg::PAT_ALTERNATE;
    else if (!have_ip) ns_pat = ssle_pkg::PAT_DARK;
    else if (dup_ip) ns_pat = ssle_pkg::PAT_RED_ON;
    else if (timeout_r) ns_pat = ssle_pkg::PAT_RED_FLASH;
    else if (connected) ns_pat = ssle_pkg::PAT_GREEN_ON;
    else ns_pat = ssle_pkg::PAT_GREEN_FLASH;
  end

  function automatic ssle_pkg::ssle_duo_t drive(ssle_pkg::ssle_pattern_t p, logic ph);
    ssle_pkg::ssle_duo_t d;
    d = '0;
    case (p)
      ssle_pkg::PAT_GREEN_ON: d.green = 1'b1;
      ssle_pkg::PAT_GREEN_FLASH: d.green = ph;
      ssle_pkg::PAT_RED_ON: d.red = 1'b1;
      ssle_pkg::PAT_RED_FLASH: d.red = ph;
      ssle_pkg::PAT_ALTERNATE: begin
        d.green = ph;
        d.red = ~ph;
      end
      default: d = '0;
    endcase
    return d;
  endfunction : drive

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ms_r <= '0;
      ns_r <= '0;
    end else begin
      ms_r <= drive(ms_pat, flash);
      ns_r <= drive(ns_pat, flash);
    end
  end
  assign module_state_indicator = ms_r;
  assign network_state_indicator = ns_r;

  ssle_port_leds u_port_zero (
    .sys_clk(sys_clk),
    .reset(reset),
    .link_up(port_zero_link),
    .frame_seen(port_zero_frame),
    .flicker(flicker),
    .leds(port_zero_leds)
  );
  ssle_port_leds u_port_one (
    .sys_clk(sys_clk),
    .reset(reset),
    .link_up(port_one_link),
    .frame_seen(port_one_frame),
    .flicker(flicker),
    .leds(port_one_leds)
  );

  chk_ms_green_on: assert property (@(posedge sys_clk) disable iff (reset)
    (configured & !selftest & !major & !minor) |=> ms_r == 2'b10)
    else $error("module indicator not steady green");
  chk_ms_green_flash: assert property (@(posedge sys_clk) disable iff (reset)
    (!configured & !selftest & !major & !minor) |=> ms_r == {$past(flash), 1'b0})
    else $error("module indicator not flashing green");
  chk_ms_major: assert property (@(posedge sys_clk) disable iff (reset)
    (major & !selftest) |=> ms_r == 2'b01) else $error("major fault not steady red");
  chk_ms_minor: assert property (@(posedge sys_clk) disable iff (reset)
    (minor & !major & !selftest) |=> ms_r == {1'b0, $past(flash)})
    else $error("minor fault not flashing red");
  chk_badcfg_minor: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl_r[ssle_pkg::CTRL_BADCFG_BIT] & !major & !selftest) |=> !ms_r.green)
    else $error("bad configuration shows green");
  chk_ms_selftest: assert property (@(posedge sys_clk) disable iff (reset)
    selftest |=> ms_r.green != ms_r.red) else $error("module self-test not alternating");
  chk_ns_selftest: assert property (@(posedge sys_clk) disable iff (reset)
    selftest |=> ns_r == ms_r) else $error("network self-test not alternating");
  chk_ns_connected: assert property (@(posedge sys_clk) disable iff (reset)
    (connected & have_ip & !dup_ip & !timeout_r & !selftest) |=> ns_r == 2'b10)
    else $error("connected not steady green");
  chk_ns_dup: assert property (@(posedge sys_clk) disable iff (reset)
    (dup_ip & have_ip & !selftest) |=> ns_r == 2'b01) else $error("duplicate ip not red");
  chk_ns_dark: assert property (@(posedge sys_clk) disable iff (reset)
    (!have_ip & !selftest) |=> ns_r == 2'b00) else $error("network lit without ip");
  chk_timeout_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (timeout_r & !to_clear) |=> timeout_r) else $error("timeout flag dropped early");
  chk_timeout_set: assert property (@(posedge sys_clk) disable iff (reset)
    conn_timeout_evt |=> timeout_r) else $error("timeout event lost");
endmodule : ssle_top

//--- testbench/ssle_panel_model.sv
// Front-panel model that tallies lit cycles of every indicator
`timescale 1ns/1ps
module ssle_panel_model (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic meas,
  input wire ssle_pkg::ssle_duo_t mod_ind,
  input wire ssle_pkg::ssle_duo_t net_ind,
  input wire ssle_pkg::ssle_port_leds_t p0,
  input wire ssle_pkg::ssle_port_leds_t p1,
  output logic [7:0][7:0] cnt
);
  logic [7:0] lit;
  assign lit = {p1.traffic, p1.link, p0.traffic, p0.link,
                net_ind.red, net_ind.green, mod_ind.red, mod_ind.green};
  // Judged by duty over whole periods, so flash phase does not matter
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (clr) cnt[i] <= 8'h00;
      else if (meas) cnt[i] <= cnt[i] + {7'h00, lit[i]};
    end
  end
endmodule : ssle_panel_model

//--- testbench/tb.sv
// Self-checking bench of the status indicator encoder
`timescale 1ns/1ps
module tb;
  localparam int W = 16;
  logic sys_clk = 0, reset = 1, clr = 0, meas = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  // Response ready held high for the whole run, so back-to-back calls never re-drive it
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic evt = 0, rst_ok = 0, l0 = 0, f0 = 0, l1 = 0, f1 = 0;
  logic [31:0] d;
  ssle_pkg::ssle_duo_t mi, ni;
  ssle_pkg::ssle_port_leds_t p0, p1;
  logic [7:0][7:0] cnt;
  int miscompares = 0, n_checks = 0, cyc = 0;

  ssle_top #(.FLASH_HALF_CYC(4), .TRAFFIC_HALF_CYC(2)) uut (.sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conn_timeout_evt(evt), .conn_all_restored(rst_ok), .port_zero_link(l0),
    .port_zero_frame(f0), .port_one_link(l1), .port_one_frame(f1),
    .module_state_indicator(mi), .network_state_indicator(ni),
    .port_zero_leds(p0), .port_one_leds(p1));
  ssle_panel_model panel (.sys_clk(sys_clk), .clr(clr), .meas(meas), .mod_ind(mi),
    .net_ind(ni), .p0(p0), .p1(p1), .cnt(cnt));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog: far above the cycles the scenarios need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Each handshake is judged at the rising edge that moves it
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && awready) begin
        awvalid <= 0;
        ad = 1;
      end
      if (!wd && wready) begin
        wvalid <= 0;
        wd = 1;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 0;
    do @(posedge sys_clk); while (!rvalid);
    v = rdata;
    r = rresp;
  endtask : rd
  task automatic look;
    @(posedge sys_clk);
    clr <= 1;
    @(posedge sys_clk);
    clr <= 0;
    meas <= 1;
    repeat (W) @(posedge sys_clk);
    meas <= 0;
    @(posedge sys_clk);
  endtask : look
  task automatic pulse(input logic e, input logic c);
    @(posedge sys_clk);
    evt <= e;
    rst_ok <= c;
    @(posedge sys_clk);
    evt <= 0;
    rst_ok <= 0;
  endtask : pulse

  task automatic t_reset;
    look();
    chk({cnt[0], cnt[1], cnt[2], cnt[3]}, 32'h08080808);
    rd(ssle_pkg::REG_CTRL_ADDR, d, resp);
    chk(d, 32'h00000001);
    rd(12'h00c, d, resp);
    chk(d, 32'h0);
    chk({30'h0, resp}, {30'h0, ssle_pkg::RESP_SLVERR});
    wr(12'h00c, 32'h0, resp);
    chk({30'h0, resp}, {30'h0, ssle_pkg::RESP_SLVERR});
  endtask : t_reset
  // Expected tallies packed as module green, red, network green, red
  task automatic t_states;
    logic [7:0] c [9] = '{8'h22, 8'ha2, 8'h20, 8'h06, 8'h0a, 8'h12, 8'he2, 8'h0e, 8'hef};
    logic [31:0] e [9] = '{32'h10000800, 32'h10001000, 32'h08000800, 32'h00100000,
      32'h00080000, 32'h00080000, 32'h10000010, 32'h00100000, 32'h08080808};
    for (int i = 0; i < 9; i++) begin
      wr(ssle_pkg::REG_CTRL_ADDR, {24'h0, c[i]}, resp);
      look();
      chk({cnt[0], cnt[1], cnt[2], cnt[3]}, e[i]);
    end
  endtask : t_states
  task automatic t_timeout;
    wr(ssle_pkg::REG_CTRL_ADDR, 32'ha2, resp);
    pulse(1, 0);
    look();
    chk({cnt[2], cnt[3]}, 16'h0008);
    rd(ssle_pkg::REG_STAT_ADDR, d, resp);
    chk(d[3], 1'b1);
    pulse(1, 1);
    look();
    chk({cnt[2], cnt[3]}, 16'h0008);
    pulse(0, 1);
    look();
    chk({cnt[2], cnt[3]}, 16'h1000);
    pulse(1, 0);
    wr(ssle_pkg::REG_TOCLR_ADDR, 32'h1, resp);
    look();
    chk({cnt[2], cnt[3]}, 16'h1000);
    pulse(1, 0);
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    wr(ssle_pkg::REG_CTRL_ADDR, 32'ha2, resp);
    look();
    chk({cnt[2], cnt[3]}, 16'h1000);
  endtask : t_timeout
  task automatic t_ports;
    @(posedge sys_clk);
    f0 <= 1;
    l1 <= 1;
    f1 <= 1;
    look();
    chk({cnt[4], cnt[5], cnt[6], cnt[7]}, 32'h00001008);
    l0 <= 1;
    f0 <= 0;
    l1 <= 0;
    // Let the held activity of the old frames run out first
    repeat (8) @(posedge sys_clk);
    look();
    chk({cnt[4], cnt[5], cnt[6], cnt[7]}, 32'h10000000);
  endtask : t_ports

  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 0;
    t_reset();
    t_states();
    t_timeout();
    t_ports();
    finish_test();
  end
endmodule : tb
